// ### core/lpmc_ctrl.sv
/*
  Low-power mode controller: Idle and four Sleep variants, retention
  lockout timed on the slow RC clock, wake-up and APB registers.
  Assumes the CPU pulses instruction completion on pclk, interrupt
  and watchdog inputs come from pclk logic, and the slow RC clock,
  master clear and power-on reset arrive asynchronously.
*/
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps

// Notes on behaviour
// - Idle halts CPU until a wake event.
// - Idle entry clears the watchdog count.
// - System clock keeps running during Idle.
// - Slow RC runs in Idle if watchdog/monitor on.
// - Idle ends on interrupt, reset or watchdog.
// - Wake resumes CPU at once, next or INTERRUPT_SERVICE_ROUTINE.
// - Interrupt during non-retention entry is deferred, then wakes.
// - Retention only in Sleep, fuse low, enable set.
// - Fast-wake bit keeps band gaps on in Sleep.
// - Standard Sleep wake sources also end retention.
// - During lockout only power-on or master clear.
// - Lockout interrupts masked; need fresh assertion after.
// - Lockout counts slow RC periods, not pclk.
// - Lockout two periods plus start-up, else one.
// - Two bits select one of four Sleep variants.
module lpmc_ctrl #(
  parameter int RC_WAKE_CYC = lpmc_pkg::LPMC_RC_WAKE_CYC
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // CPU side
  input  wire logic        power_save_instruction,
  input  wire logic        power_save_operand,
  input  wire logic        irq_pending,
  output logic             cpu_halt,
  output logic             cpu_resume,
  output logic             resume_to_isr,
  // Reset sources, watchdog, configuration
  input  wire logic        master_clear_pin_n,
  input  wire logic        power_on_reset,
  input  wire logic        watchdog_timeout,
  input  wire logic        watchdog_enable,
  input  wire logic        fail_safe_clock_monitor,
  input  wire logic [15:0] power_on_config_word,
  output logic             watchdog_counter_clear,
  // Clocks and regulators
  input  wire logic        low_power_rc_clock,
  output logic             sysclk_run,
  output logic             low_power_rc_enable,
  output logic             retention_regulator_en,
  output logic             bandgap_en,
  output logic [1:0]       sleep_mode
);
  import lpmc_pkg::*;

  // Refuse a start-up count the wait counter cannot hold
  if (RC_WAKE_CYC < 1 || RC_WAKE_CYC > 65535) begin : g_chk
    $error("RC_WAKE_CYC out of range");
  end

  lpmc_state_type state_q, state_d;
  logic [31:0] rstctl_q;
  logic [1:0]  mode_q;
  logic        pend_q, irq_prev_q, isr_q;
  logic [15:0] wait_q;
  logic [1:0]  edges_q;
  logic        rc_s1_q, rc_s2_q, rc_s3_q;
  logic        mc_s1_q, mc_s2_q, po_s1_q, po_s2_q;
  logic        pready_q, pslverr_q, resume_q, wdclr_q;
  logic [31:0] prdata_q;
  logic        halt_q, sysclk_q, rcen_q, retention_sleep_enable_q, bg_q;

  // Asynchronous inputs: first flop feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
      mc_s1_q <= 1'b0;
      mc_s2_q <= 1'b0;
      po_s1_q <= 1'b0;
      po_s2_q <= 1'b0;
    end else begin
      rc_s1_q <= low_power_rc_clock;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
      mc_s1_q <= ~master_clear_pin_n;
      mc_s2_q <= mc_s1_q;
      po_s1_q <= power_on_reset;
      po_s2_q <= po_s1_q;
    end
  end

  // Decode of the APB access
  wire         acc      = psel & penable & pready_q;
  wire         setup    = psel & ~penable;
  wire         hit_ctl  = (paddr == LPMC_RSTCTL_OFS);
  wire         hit_stat = (paddr == LPMC_STATUS_OFS);
  wire         wr_ctl   = acc & pwrite & hit_ctl & ~pslverr_q;
  wire [31:0]  status   = {15'h0000, isr_q, 3'h0,
                           state_q == LPMC_ST_LOCK, 2'h0, mode_q,
                           3'h0, state_q};
  wire [31:0]  rd_data  = hit_ctl ? rstctl_q : (hit_stat ? status : 32'h0);

  // Sleep variant select; retention needs fuse low and enable set
  wire ret_ok   = ~power_on_config_word[LPMC_CFG_RET_BIT]
                & rstctl_q[LPMC_RET_EN_BIT];
  wire [1:0] mode_sel = {ret_ok, rstctl_q[LPMC_FAST_BIT]};

  // Wake sources; reset events beat the lockout
  wire rc_edge    = rc_s2_q & ~rc_s3_q;
  wire rst_wake   = mc_s2_q | po_s2_q;
  wire irq_rise   = irq_pending & ~irq_prev_q;
  wire irq_wake   = (mode_q[1] & ~idle_q) ? irq_rise
                  : (irq_pending | pend_q);
  wire any_wake   = rst_wake | watchdog_timeout | irq_wake;
  wire lock_done  = (wait_q == 16'h0000) & (edges_q == 2'h1) & rc_edge;
  wire rc_on_need = watchdog_enable | fail_safe_clock_monitor;

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LPMC_ST_RUN:
        if (power_save_instruction) state_d = LPMC_ST_ENTER;
      LPMC_ST_ENTER:
        if (idle_q) state_d = LPMC_ST_IDLE;
        else if (mode_q[1]) state_d = LPMC_ST_LOCK;
        else state_d = LPMC_ST_SLEEP;
      LPMC_ST_IDLE, LPMC_ST_SLEEP:
        if (any_wake) state_d = LPMC_ST_RUN;
      LPMC_ST_LOCK:
        if (rst_wake) state_d = LPMC_ST_RUN;
        else if (lock_done) state_d = LPMC_ST_SLEEP;
      default: state_d = LPMC_ST_RUN;
    endcase
  end

  wire entering  = (state_q == LPMC_ST_RUN) & power_save_instruction;
  wire to_idle   = (state_q == LPMC_ST_ENTER) & (state_d == LPMC_ST_IDLE);
  wire waking    = (state_d == LPMC_ST_RUN) & (state_q != LPMC_ST_RUN);
  wire halted_d  = (state_d != LPMC_ST_RUN);
  wire sleep_d   = (state_d == LPMC_ST_SLEEP) | (state_d == LPMC_ST_LOCK);
  wire [15:0] wait_cyc = 16'(RC_WAKE_CYC);

  // Mode latch: idle is coded {1, op}, sleep variants in mode_q
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= LPMC_MODE_SLEEP;
    end else if (entering) begin
      mode_q <= (power_save_operand == LPMC_OP_IDLE) ?
                {1'b1, LPMC_OP_IDLE} : mode_sel;
    end
  end

  // Separate Idle flag, since Fast Retention shares mode code 3
  logic idle_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 1'b0;
    end else if (entering) begin
      idle_q <= (power_save_operand == LPMC_OP_IDLE);
    end
  end

  // Controller state and deferred interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= LPMC_ST_RUN;
      pend_q     <= 1'b0;
      irq_prev_q <= 1'b0;
      isr_q      <= 1'b0;
    end else begin
      // Idle, Sleep or lockout is picked in the next-state logic
      state_q    <= state_d;
      irq_prev_q <= irq_pending;
      // Lockout forgets anything seen before it
      if (state_q == LPMC_ST_LOCK || waking) pend_q <= 1'b0;
      else if (state_q == LPMC_ST_ENTER && irq_pending)
        pend_q <= 1'b1;
      if (waking) isr_q <= irq_wake & ~rst_wake;
    end
  end

  // Lockout timer on slow RC edges, after start-up if it was off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q  <= 16'h0000;
      edges_q <= 2'h0;
    end else if (state_q == LPMC_ST_ENTER) begin
      wait_q  <= rcen_q ? 16'h0000 : wait_cyc;
      edges_q <= rcen_q ? LPMC_LOCK_WARM_PER : LPMC_LOCK_COLD_PER;
    end else if (state_q == LPMC_ST_LOCK) begin
      if (wait_q != 16'h0000) wait_q <= wait_q - 16'h0001;
      else if (rc_edge && edges_q != 2'h1)
        edges_q <= edges_q - 2'h1;
    end
  end

  // Registered outputs toward CPU, clocks and regulators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q   <= 1'b0;
      resume_q <= 1'b0;
      wdclr_q  <= 1'b0;
      sysclk_q <= 1'b1;
      rcen_q   <= 1'b0;
      retention_sleep_enable_q  <= 1'b0;
      bg_q     <= 1'b1;
    end else begin
      halt_q   <= halted_d;
      resume_q <= waking;
      wdclr_q  <= to_idle;
      sysclk_q <= ~(sleep_d & ~idle_q);
      rcen_q   <= rc_on_need | (state_d == LPMC_ST_LOCK);
      retention_sleep_enable_q  <= sleep_d & ~idle_q & mode_q[1];
      bg_q     <= ~(sleep_d & ~idle_q) | mode_q[0];
    end
  end

  // Reset control register; write lands in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rstctl_q <= LPMC_RSTCTL_RST;
    end else if (wr_ctl) begin
      rstctl_q <= (32'h1 << LPMC_RET_EN_BIT | 32'h1 << LPMC_FAST_BIT)
                  & pwdata;
    end
  end

  // APB answer prepared in setup so access ends after one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~(hit_ctl | (hit_stat & ~pwrite));
      prdata_q  <= (setup & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign prdata                 = prdata_q;
  assign cpu_halt               = halt_q;
  assign cpu_resume             = resume_q;
  assign resume_to_isr          = isr_q;
  assign watchdog_counter_clear = wdclr_q;
  assign sysclk_run             = sysclk_q;
  assign low_power_rc_enable    = rcen_q;
  assign retention_regulator_en = retention_sleep_enable_q;
  assign bandgap_en             = bg_q;
  assign sleep_mode             = mode_q;

  // Checks on the controller's own behaviour
  property p_idle_halts;
    @(posedge pclk) disable iff (!presetn)
      (state_q == LPMC_ST_IDLE) |-> cpu_halt;
  endproperty
  a_idle_halts: assert property (p_idle_halts)
    else $error("CPU not halted in Idle");

  property p_wd_clear;
    @(posedge pclk) disable iff (!presetn)
      $rose(state_q == LPMC_ST_IDLE) |-> watchdog_counter_clear;
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("Watchdog not cleared on Idle entry");

  property p_idle_clock;
    @(posedge pclk) disable iff (!presetn)
      (state_q == LPMC_ST_IDLE) [*2] |-> sysclk_run;
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("System clock stopped in Idle");

  property p_rc_kept;
    @(posedge pclk) disable iff (!presetn)
      (state_q == LPMC_ST_IDLE && $past(rc_on_need)) |-> low_power_rc_enable;
  endproperty
  a_rc_kept: assert property (p_rc_kept)
    else $error("Slow RC stopped in Idle");

  property p_wd_wake;
    @(posedge pclk) disable iff (!presetn)
      (state_q == LPMC_ST_IDLE && watchdog_timeout)
        |=> (state_q == LPMC_ST_RUN) ##0 cpu_resume;
  endproperty
  a_wd_wake: assert property (p_wd_wake)
    else $error("No wake on watchdog time-out");

  property p_deferred;
    @(posedge pclk) disable iff (!presetn)
      (state_q == LPMC_ST_ENTER && irq_pending && idle_q)
        |=> (state_q == LPMC_ST_IDLE) ##1 (state_q == LPMC_ST_RUN);
  endproperty
  a_deferred: assert property (p_deferred)
    else $error("Coincident interrupt lost");

  property p_lock_mask;
    @(posedge pclk) disable iff (!presetn)
      (state_q == LPMC_ST_LOCK && !rst_wake && !lock_done)
        |=> (state_q == LPMC_ST_LOCK);
  endproperty
  a_lock_mask: assert property (p_lock_mask)
    else $error("Lockout ended early");

  property p_ret_only_sleep;
    @(posedge pclk) disable iff (!presetn)
      retention_regulator_en |-> !sysclk_run && sleep_mode[1];
  endproperty
  a_ret_only_sleep: assert property (p_ret_only_sleep)
    else $error("Retention regulator outside retention Sleep");

  property p_bandgap;
    @(posedge pclk) disable iff (!presetn)
      (!sysclk_run && sleep_mode[0]) |-> bandgap_en;
  endproperty
  a_bandgap: assert property (p_bandgap)
    else $error("Band gaps off in fast Sleep");

  property p_cold_lock;
    @(posedge pclk) disable iff (!presetn)
      (state_q == LPMC_ST_ENTER && mode_q[1] && !idle_q && !rcen_q)
        |=> (wait_q == wait_cyc) && (edges_q == LPMC_LOCK_COLD_PER);
  endproperty
  a_cold_lock: assert property (p_cold_lock)
    else $error("Cold lockout length wrong");

endmodule : lpmc_ctrl

// ### core/lpmc_pkg.sv
/*
  Shared constants for the low-power mode controller: register map,
  field positions, reset values, mode codes and timing counts.
  Assumes a 125 MHz APB clock and 32-bit APB data.
*/
package lpmc_pkg;

  // Register byte offsets
  localparam logic [7:0] LPMC_RSTCTL_OFS = 8'h00;
  localparam logic [7:0] LPMC_STATUS_OFS = 8'h04;

  // Reset control register fields
  localparam int LPMC_RET_EN_BIT = 12;
  localparam int LPMC_FAST_BIT   = 8;
  localparam logic [31:0] LPMC_RSTCTL_RST = 32'h0000_0000;

  // Configuration word field (programmed low enables retention)
  localparam int LPMC_CFG_RET_BIT = 2;

  // Status register fields
  localparam int LPMC_ST_STATE_LSB = 0;  // five state bits
  localparam int LPMC_ST_MODE_LSB  = 8;  // two sleep variant bits
  localparam int LPMC_ST_LOCK_BIT  = 12;
  localparam int LPMC_ST_ISR_BIT   = 16;

  // Power-save instruction operand
  localparam logic LPMC_OP_SLEEP = 1'b0;
  localparam logic LPMC_OP_IDLE  = 1'b1;

  // Sleep variants, {retention, fast wake}
  localparam logic [1:0] LPMC_MODE_SLEEP = 2'h0;
  localparam logic [1:0] LPMC_MODE_FAST  = 2'h1;
  localparam logic [1:0] LPMC_MODE_RET   = 2'h2;
  localparam logic [1:0] LPMC_MODE_FRET  = 2'h3;

  // Lockout lengths in slow RC periods
  localparam logic [1:0] LPMC_LOCK_COLD_PER = 2'h2;
  localparam logic [1:0] LPMC_LOCK_WARM_PER = 2'h1;

  // Slow RC start-up time and its count of pclk cycles (rounded up)
  localparam int LPMC_CLK_MHZ      = 125;
  localparam int LPMC_RC_WAKE_NS   = 1000;
  localparam int LPMC_RC_WAKE_CYC  =
    (LPMC_RC_WAKE_NS * LPMC_CLK_MHZ + 999) / 1000;

  // Controller states, one-hot
  typedef enum logic [4:0] {
    LPMC_ST_RUN   = 5'h01,
    LPMC_ST_ENTER = 5'h02,
    LPMC_ST_IDLE  = 5'h04,
    LPMC_ST_SLEEP = 5'h08,
    LPMC_ST_LOCK  = 5'h10
  } lpmc_state_type;

endpackage : lpmc_pkg

// ### bench/lpmc_rc_model.sv
/*
  Slow RC oscillator at the far side of the controller.
  Assumes the enable comes from the controller on pclk.
*/
`timescale 1ns/10ps

module lpmc_rc_model #(
  parameter int HALF_NS = 160
) (
  // Oscillator control and output
  input  wire logic enable,
  output logic      rc_clk
);
  // Stands low while stopped, so no stale edge leaks into a lockout
  always begin
    rc_clk = 1'b0;
    wait (enable === 1'b1);
    while (enable === 1'b1) begin
      #(HALF_NS);
      rc_clk = ~rc_clk;
    end
  end
endmodule : lpmc_rc_model

// ### bench/tb_top.sv
/*
  Self-checking bench for the low-power mode controller.
  Assumes a 125 MHz pclk and the slow RC model at 40 pclk periods.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module tb_top;
  import lpmc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        power_save_instruction, power_save_operand, irq_pending;
  logic        cpu_halt, cpu_resume, resume_to_isr, master_clear_pin_n;
  logic        power_on_reset, watchdog_timeout, watchdog_enable;
  logic        fail_safe_clock_monitor, watchdog_counter_clear;
  logic [15:0] power_on_config_word;
  logic        low_power_rc_clock, sysclk_run, low_power_rc_enable;
  logic        retention_regulator_en, bandgap_en;
  logic [1:0]  sleep_mode;
  int          mismatches, total_checks, cyc, n_wdclr, n_res, t_cold, t_warm;

  lpmc_ctrl #(.RC_WAKE_CYC(2)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .power_save_instruction, .power_save_operand,
    .irq_pending, .cpu_halt, .cpu_resume, .resume_to_isr,
    .master_clear_pin_n, .power_on_reset, .watchdog_timeout,
    .watchdog_enable, .fail_safe_clock_monitor, .power_on_config_word,
    .watchdog_counter_clear, .low_power_rc_clock, .sysclk_run,
    .low_power_rc_enable, .retention_regulator_en, .bandgap_en, .sleep_mode
  );

  lpmc_rc_model #(.HALF_NS(160)) rc (
    .enable (low_power_rc_enable),
    .rc_clk (low_power_rc_clock)
  );

  // Clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Pulse counters and hang guard, mid-cycle where pulses stand
  always @(negedge pclk) begin
    cyc++;
    if (watchdog_counter_clear === 1'b1) n_wdclr++;
    if (cpu_resume === 1'b1) n_res++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  task complete_run;
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_halt(input logic v);
    int n;
    n = 0;
    while (cpu_halt !== v && n < 400) begin
      @(posedge pclk);
      n++;
    end
    `CHK("cpu_halt", v, cpu_halt)
  endtask : wait_halt

  // Power-save instruction, optionally with a coincident interrupt
  task automatic psave(input logic op, input logic coin);
    @(posedge pclk);
    power_save_instruction <= 1'b1;
    power_save_operand <= op;
    if (coin) irq_pending <= 1'b1;
    @(posedge pclk);
    power_save_instruction <= 1'b0;
    wait_halt(1'b1);
  endtask : psave

  // Retention entry, lockout timing and a fresh wake edge afterwards
  task automatic ret_run(input logic fast, input logic wd, output int t);
    int t0;
    watchdog_enable <= wd;
    apb(1'b1, LPMC_RSTCTL_OFS, 32'h0000_1000 | (32'(fast) << 8));
    repeat (60) @(posedge pclk);
    psave(LPMC_OP_SLEEP, 1'b0);
    repeat (2) @(posedge pclk);
    irq_pending <= 1'b1;
    t0 = cyc;
    apb(1'b0, LPMC_STATUS_OFS, 32'h0);
    `CHK("lock", 1'b1, rd[LPMC_ST_LOCK_BIT])
    `CHK("ret_reg", 1'b1, retention_regulator_en)
    `CHK("mode", {1'b1, fast}, sleep_mode)
    `CHK("bandgap", fast, bandgap_en)
    while (rd[LPMC_ST_LOCK_BIT] === 1'b1 && cyc - t0 < 600)
      apb(1'b0, LPMC_STATUS_OFS, 32'h0);
    t = cyc - t0;
    `CHK("masked", 1'b1, cpu_halt)
    irq_pending <= 1'b0;
    repeat (3) @(posedge pclk);
    irq_pending <= 1'b1;
    wait_halt(1'b0);
    irq_pending <= 1'b0;
  endtask : ret_run

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {power_save_instruction, power_save_operand, irq_pending} = '0;
    {power_on_reset, watchdog_timeout, watchdog_enable} = '0;
    fail_safe_clock_monitor = 1'b0;
    master_clear_pin_n = 1'b1;
    power_on_config_word = 16'h0004;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    // Register reset values, access kinds and refusals
    apb(1'b0, LPMC_RSTCTL_OFS, 32'h0);
    `CHK("ctl_rst", LPMC_RSTCTL_RST, rd)
    apb(1'b0, LPMC_STATUS_OFS, 32'h0);
    `CHK("status_rst", 32'h0000_0001, rd)
    apb(1'b1, LPMC_RSTCTL_OFS, 32'hFFFF_FFFF);
    apb(1'b0, LPMC_RSTCTL_OFS, 32'h0);
    `CHK("ctl_rw", 32'h0000_1100, rd)
    apb(1'b1, LPMC_STATUS_OFS, 32'h0);
    `CHK("status_ro", 1'b1, err)
    apb(1'b0, 8'h08, 32'h0);
    `CHK("unmapped", 1'b1, err)
    // Idle with watchdog woken by interrupt, then Idle with monitor woken by time-out
    watchdog_enable <= 1'b1;
    psave(LPMC_OP_IDLE, 1'b0);
    apb(1'b0, LPMC_STATUS_OFS, 32'h0);
    `CHK("idle", 5'h04, rd[4:0])
    `CHK("wdclr", 1, n_wdclr)
    `CHK("sysclk", 1'b1, sysclk_run)
    `CHK("rc_wd", 1'b1, low_power_rc_enable)
    irq_pending <= 1'b1;
    wait_halt(1'b0);
    `CHK("to_isr", 1'b1, resume_to_isr)
    `CHK("resume", 1, n_res)
    irq_pending <= 1'b0;
    watchdog_enable <= 1'b0;
    fail_safe_clock_monitor <= 1'b1;
    psave(LPMC_OP_IDLE, 1'b0);
    repeat (2) @(posedge pclk);
    `CHK("rc_mon", 1'b1, low_power_rc_enable)
    watchdog_timeout <= 1'b1;
    wait_halt(1'b0);
    watchdog_timeout <= 1'b0;
    `CHK("to_next", 1'b0, resume_to_isr)
    fail_safe_clock_monitor <= 1'b0;
    // Interrupt coincident with the instruction is held, then wakes
    psave(LPMC_OP_IDLE, 1'b1);
    wait_halt(1'b0);
    irq_pending <= 1'b0;
    `CHK("coin_isr", 1'b1, resume_to_isr)
    // Fuse blocks retention: every bit pair falls back by fast bit
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, LPMC_RSTCTL_OFS, (32'(i[1]) << 12) | (32'(i[0]) << 8));
      psave(LPMC_OP_SLEEP, 1'b0);
      repeat (2) @(posedge pclk);
      `CHK("fb_mode", {1'b0, i[0]}, sleep_mode)
      `CHK("fb_bg", i[0], bandgap_en)
      `CHK("fb_ret", 1'b0, retention_regulator_en)
      `CHK("fb_clk", 1'b0, sysclk_run)
      irq_pending <= 1'b1;
      wait_halt(1'b0);
      irq_pending <= 1'b0;
    end
    `CHK("wdclr_n", 3, n_wdclr)
    // Retention: cold lockout is longer than warm, both on slow RC
    power_on_config_word <= 16'h0000;
    ret_run(1'b0, 1'b0, t_cold);
    ret_run(1'b1, 1'b1, t_warm);
    `CHK("lock_cold", 1'b1, t_cold > 40)
    `CHK("lock_warm", 1'b1, t_warm < 50)
    // Master clear ends retention inside the lockout
    watchdog_enable <= 1'b0;
    apb(1'b1, LPMC_RSTCTL_OFS, 32'h0000_1000);
    repeat (60) @(posedge pclk);
    psave(LPMC_OP_SLEEP, 1'b0);
    repeat (4) @(posedge pclk);
    master_clear_pin_n <= 1'b0;
    wait_halt(1'b0);
    `CHK("mc_isr", 1'b0, resume_to_isr)
    master_clear_pin_n <= 1'b1;
    repeat (10) @(posedge pclk);
    complete_run();
  end
endmodule : tb_top
